/* hw/flash_host_ctl.sv */
// host controller issuing byte-mode command sequences to a parallel flash
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_params.svh"
module flash_host_ctl
  import flash_ctl_pkg::*;
#(
  parameter int AW    = 27,
  parameter int DEPTH = 256
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata_q,
  output logic               pready_q,
  output logic               pslverr_q,
  // flash pins
  output logic               flash_ce_n,
  output logic               flash_we_n,
  output logic               flash_oe_n,
  output logic      [AW-1:0] flash_addr,
  output logic      [7:0]    flash_dq_o,
  output logic               flash_dq_oe,
  input  wire logic [7:0]    flash_dq_i
);
  localparam int BW = $clog2(DEPTH);

  seq_state_e    st_q, st_d;
  op_e           op_q, op_d;
  logic [2:0]    idx_q, idx_d;
  logic [BW-1:0] bidx_q, bidx_d, bwp_q, bwp_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [7:0]    data_q, data_d, cnt_q, cnt_d, rd_q, rd_d;
  logic          bypass_q, bypass_d, ovl_q, ovl_d, refused_q, refused_d;
  logic [1:0]    pwd_next_q, pwd_next_d;
  logic [31:0]   prdata_d;
  logic          pready_d, pslverr_d;
  logic          eng_start, eng_done;
  logic [AW-1:0] eng_addr;
  logic [7:0]    eng_wdata, eng_rdata, buf_rdata;
  logic          buf_we, wr_acc, busy, ok;
  op_e           new_op;
  step_s         step;

  function automatic step_s mk(kind_e k, logic [11:0] a, logic [7:0] d);
    step_s s;
    s.kind = k;
    s.addr = a;
    s.data = d;
    return s;
  endfunction : mk

  function automatic logic needs_unlock(op_e op);
    case (op)
      OP_PROG, OP_BUF_PROG, OP_ABORT_RST, OP_BYP_ENTER, OP_CHIP_ERASE,
      OP_SECT_ERASE, OP_ID_ENTRY, OP_SSR_ENTRY, OP_LOCK_ENTRY,
      OP_PWD_ENTRY: return 1'b1;
      default:      return 1'b0;
    endcase
  endfunction : needs_unlock

  // command part of each sequence, after any unlock pair
  function automatic step_s body_of(op_e op, logic [2:0] j);
    step_s s;
    s = mk(K_END, `ANY_ADDR, 8'h00);
    case (op)
      OP_READ: if (j == 3'd0) s = mk(K_RD_USR, `ANY_ADDR, 8'h00);
      OP_RESET: if (j == 3'd0) s = mk(K_WR, `ANY_ADDR, `CMD_RESET);
      OP_SR_READ: begin
        if (j == 3'd0) s = mk(K_WR, `UNL_ADDR1, `CMD_SR_READ);
        if (j == 3'd1) s = mk(K_RD_USR, `ANY_ADDR, 8'h00);
      end
      OP_SR_CLEAR: if (j == 3'd0) s = mk(K_WR, `UNL_ADDR1, `CMD_SR_CLEAR);
      OP_PROG, OP_BYP_PROG, OP_OVL_PROG, OP_PWD_PROG: begin
        if (j == 3'd0) s = mk(K_WR, `UNL_ADDR1, `CMD_PROG);
        if (j == 3'd1) s = mk(K_WR_USR, `ANY_ADDR, 8'h00);
      end
      OP_BUF_PROG, OP_BYP_BUF: begin
        if (j == 3'd0) s = mk(K_WR_SA, `ANY_ADDR, `CMD_BUF_LOAD);
        if (j == 3'd1) s = mk(K_WR_CNT, `ANY_ADDR, 8'h00);
        if (j == 3'd2) s = mk(K_WR_BUF, `ANY_ADDR, 8'h00);
        if (j == 3'd3) s = mk(K_WR_SA, `ANY_ADDR, `CMD_BUF_CONFIRM);
      end
      OP_ABORT_RST: if (j == 3'd0) s = mk(K_WR, `UNL_ADDR1, `CMD_RESET);
      OP_BYP_ENTER: if (j == 3'd0) s = mk(K_WR, `UNL_ADDR1, `CMD_BYP_ENTER);
      OP_BYP_EXIT, OP_SET_EXIT: begin
        if (j == 3'd0) s = mk(K_WR, `ANY_ADDR, `CMD_EXIT1);
        if (j == 3'd1) s = mk(K_WR, `ANY_ADDR, `CMD_EXIT2);
      end
      OP_CHIP_ERASE, OP_SECT_ERASE: begin
        if (j == 3'd0) s = mk(K_WR, `UNL_ADDR1, `CMD_ERASE);
        if (j == 3'd1) s = mk(K_WR, `UNL_ADDR1, `UNL_DATA1);
        if (j == 3'd2) s = mk(K_WR, `UNL_ADDR2, `UNL_DATA2);
        if (j == 3'd3) s = (op == OP_CHIP_ERASE)
                           ? mk(K_WR, `UNL_ADDR1, `CMD_CHIP)
                           : mk(K_WR_SA, `ANY_ADDR, `CMD_SECTOR);
      end
      OP_SUSPEND:  if (j == 3'd0) s = mk(K_WR, `ANY_ADDR, `CMD_SUSPEND);
      OP_RESUME:   if (j == 3'd0) s = mk(K_WR, `ANY_ADDR, `CMD_RESUME);
      OP_PSUSPEND: if (j == 3'd0) s = mk(K_WR, `ANY_ADDR, `CMD_PSUSPEND);
      OP_PRESUME:  if (j == 3'd0) s = mk(K_WR, `ANY_ADDR, `CMD_PRESUME);
      OP_EVAL:     if (j == 3'd0) s = mk(K_WR_SA, `UNL_ADDR1, `CMD_EVAL);
      OP_BLANK:    if (j == 3'd0) s = mk(K_WR_SA, `UNL_ADDR1, `CMD_BLANK);
      OP_CFI_ENTER: if (j == 3'd0) s = mk(K_WR_SA, `CFI_ADDR, `CMD_CFI_ENTER);
      OP_CFI_EXIT: if (j == 3'd0) s = mk(K_WR, `ANY_ADDR, `CMD_CFI_EXIT);
      OP_ID_ENTRY: if (j == 3'd0) s = mk(K_WR, `UNL_ADDR1, `CMD_ID_ENTRY);
      OP_SSR_ENTRY: if (j == 3'd0) s = mk(K_WR, `UNL_ADDR1, `CMD_SSR_ENTRY);
      OP_LOCK_ENTRY: if (j == 3'd0) s = mk(K_WR, `UNL_ADDR1, `CMD_LOCK_ENTRY);
      OP_PWD_ENTRY: if (j == 3'd0) s = mk(K_WR, `UNL_ADDR1, `CMD_PWD_ENTRY);
      default: s = mk(K_END, `ANY_ADDR, 8'h00);
    endcase
    return s;
  endfunction : body_of

  function automatic step_s step_at(op_e op, logic [2:0] i);
    if (needs_unlock(op)) begin
      if (i == 3'd0) return mk(K_WR, `UNL_ADDR1, `UNL_DATA1);
      if (i == 3'd1) return mk(K_WR, `UNL_ADDR2, `UNL_DATA2);
      return body_of(op, i - 3'd2);
    end
    return body_of(op, i);
  endfunction : step_at

  assign new_op = op_e'(pwdata[`CTRL_OP_LSB +: 5]);
  assign busy   = (st_q != SQ_IDLE);
  assign wr_acc = psel & penable & pready_q & pwrite;
  assign buf_we = wr_acc & (paddr == `REG_BUF);
  assign step   = step_at(op_q, idx_q);

  // upper address bits of command cycles stay zero; sector cycles carry
  // the caller's address above bit 11 so any sector offset works
  always_comb begin
    eng_addr  = {{(AW-12){1'b0}}, step.addr};
    eng_wdata = step.data;
    case (step.kind)
      K_WR_SA:  eng_addr = {addr_q[AW-1:12], step.addr};
      K_WR_USR, K_RD_USR: begin
        eng_addr  = addr_q;
        eng_wdata = data_q;
      end
      K_WR_CNT: begin
        eng_addr  = addr_q;
        eng_wdata = cnt_q;
      end
      K_WR_BUF: begin
        eng_addr  = addr_q + AW'(bidx_q);
        eng_wdata = buf_rdata;
      end
      default: eng_addr = {{(AW-12){1'b0}}, step.addr};
    endcase
  end

  // legality of a new order as seen from the host
  always_comb begin
    case (new_op)
      OP_BYP_PROG, OP_BYP_BUF: ok = bypass_q;
      OP_PWD_PROG: ok = ovl_q && pwdata[17:16] == pwd_next_q;
      OP_BYP_EXIT: ok = bypass_q;
      default:     ok = 1'b1;
    endcase
  end

  always_comb begin
    st_d       = st_q;
    op_d       = op_q;
    idx_d      = idx_q;
    bidx_d     = bidx_q;
    bwp_d      = buf_we ? bwp_q + BW'(1) : bwp_q;
    addr_d     = addr_q;
    data_d     = data_q;
    cnt_d      = cnt_q;
    rd_d       = rd_q;
    bypass_d   = bypass_q;
    ovl_d      = ovl_q;
    refused_d  = refused_q;
    pwd_next_d = pwd_next_q;
    eng_start  = 1'b0;
    if (wr_acc) begin
      case (paddr)
        `REG_ADDR:  addr_d = pwdata[AW-1:0];
        `REG_DATA:  data_d = pwdata[7:0];
        `REG_COUNT: cnt_d  = pwdata[7:0];
        `REG_CTRL: begin
          if (pwdata[`CTRL_START_BIT]) begin
            if (!busy && ok) begin
              op_d      = new_op;
              idx_d     = 3'd0;
              bidx_d    = '0;
              refused_d = 1'b0;
              st_d      = SQ_PREP;
            end else begin
              refused_d = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    case (st_q)
      SQ_IDLE: ;
      SQ_PREP: begin
        if (step.kind == K_END) begin
          st_d  = SQ_IDLE;
          bwp_d = '0;
          case (op_q)
            OP_BYP_ENTER: bypass_d = 1'b1;
            OP_BYP_EXIT:  bypass_d = 1'b0;
            OP_RESET, OP_SET_EXIT, OP_CFI_EXIT: ovl_d = 1'b0;
            OP_ID_ENTRY, OP_CFI_ENTER, OP_SSR_ENTRY, OP_LOCK_ENTRY:
              ovl_d = 1'b1;
            OP_PWD_ENTRY: begin
              ovl_d      = 1'b1;
              pwd_next_d = 2'd0;
            end
            OP_PWD_PROG: pwd_next_d = pwd_next_q + 2'd1;
            default: ;
          endcase
        end else begin
          st_d = SQ_ISSUE;
        end
      end
      SQ_ISSUE: begin
        eng_start = 1'b1;
        st_d      = SQ_WAIT;
      end
      SQ_WAIT: begin
        if (eng_done) begin
          st_d = SQ_PREP;
          if (step.kind == K_RD_USR) begin
            rd_d = eng_rdata;
          end
          if (step.kind == K_WR_BUF && 8'(bidx_q) != cnt_q) begin
            bidx_d = bidx_q + BW'(1);
          end else begin
            idx_d  = idx_q + 3'd1;
            bidx_d = '0;
          end
        end
      end
      default: st_d = SQ_IDLE;
    endcase
  end

  always_comb begin
    pready_d  = psel & penable & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    case (paddr)
      `REG_CTRL:   prdata_d = {27'h0, op_q};
      `REG_ADDR:   prdata_d = 32'(addr_q);
      `REG_DATA:   prdata_d = {24'h0, data_q};
      `REG_COUNT:  prdata_d = {24'h0, cnt_q};
      `REG_STATUS: prdata_d = {14'h0, pwd_next_q, rd_q,
                               4'h0, refused_q, ovl_q, bypass_q, busy};
      `REG_BUF:    prdata_d = 32'(bwp_q);
      default:     pslverr_d = pready_d;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q       <= SQ_IDLE;
      op_q       <= OP_READ;
      idx_q      <= 3'd0;
      bidx_q     <= '0;
      bwp_q      <= '0;
      addr_q     <= '0;
      data_q     <= 8'h00;
      cnt_q      <= 8'h00;
      rd_q       <= 8'h00;
      bypass_q   <= 1'b0;
      ovl_q      <= 1'b0;
      refused_q  <= 1'b0;
      pwd_next_q <= 2'd0;
      prdata_q   <= 32'h0000_0000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else begin
      st_q       <= st_d;
      op_q       <= op_d;
      idx_q      <= idx_d;
      bidx_q     <= bidx_d;
      bwp_q      <= bwp_d;
      addr_q     <= addr_d;
      data_q     <= data_d;
      cnt_q      <= cnt_d;
      rd_q       <= rd_d;
      bypass_q   <= bypass_d;
      ovl_q      <= ovl_d;
      refused_q  <= refused_d;
      pwd_next_q <= pwd_next_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
    end
  end

  flash_buf_mem #(.DW(8), .DEPTH(DEPTH)) u_buf (
    .ref_clk (ref_clk),
    .we      (buf_we),
    .waddr   (bwp_q),
    .wdata   (pwdata[7:0]),
    .raddr   (bidx_q),
    .rdata_q (buf_rdata)
  );

  flash_bus_cycle #(.AW(AW), .DW(8)) u_cyc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (eng_start),
    .rd      (step.kind == K_RD_USR),
    .addr    (eng_addr),
    .wdata   (eng_wdata),
    .done_q  (eng_done),
    .rdata_q (eng_rdata),
    .ce_n_q  (flash_ce_n),
    .we_n_q  (flash_we_n),
    .oe_n_q  (flash_oe_n),
    .a_q     (flash_addr),
    .dq_o_q  (flash_dq_o),
    .dq_oe_q (flash_dq_oe),
    .dq_i    (flash_dq_i)
  );
endmodule : flash_host_ctl
`default_nettype wire

/* common/flash_ctl_params.svh */
// offsets, command codes and timing counts of the flash host controller
`ifndef FLASH_CTL_PARAMS_SVH
`define FLASH_CTL_PARAMS_SVH

`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_DATA        8'h08
`define REG_COUNT       8'h0c
`define REG_STATUS      8'h10
`define REG_BUF         8'h14

`define CTRL_OP_LSB     0
`define CTRL_START_BIT  8

`define UNL_ADDR1       12'haaa
`define UNL_ADDR2       12'h555
`define CFI_ADDR        12'h0aa
`define ANY_ADDR        12'h000
`define UNL_DATA1       8'haa
`define UNL_DATA2       8'h55
`define CMD_PROG        8'ha0
`define CMD_BUF_LOAD    8'h25
`define CMD_BUF_CONFIRM 8'h29
`define CMD_RESET       8'hf0
`define CMD_BYP_ENTER   8'h20
`define CMD_EXIT1       8'h90
`define CMD_EXIT2       8'h00
`define CMD_ERASE       8'h80
`define CMD_CHIP        8'h10
`define CMD_SECTOR      8'h30
`define CMD_SUSPEND     8'hb0
`define CMD_RESUME      8'h30
`define CMD_PSUSPEND    8'h51
`define CMD_PRESUME     8'h50
`define CMD_EVAL        8'h35
`define CMD_BLANK       8'h33
`define CMD_CFI_ENTER   8'h98
`define CMD_CFI_EXIT    8'hff
`define CMD_ID_ENTRY    8'h90
`define CMD_SR_READ     8'h70
`define CMD_SR_CLEAR    8'h71
`define CMD_SSR_ENTRY   8'h88
`define CMD_LOCK_ENTRY  8'h40
`define CMD_PWD_ENTRY   8'h60

`define CLK_PERIOD_NS   10
`define T_SETUP_NS      20
`define T_STROBE_NS     60
`define T_HOLD_NS       20
`define T_SETUP_CYC  ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_STROBE_CYC ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_HOLD_CYC   ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_EXTRA_CYC  3

`endif

/* common/flash_ctl_pkg.sv */
// types shared by the flash host controller
package flash_ctl_pkg;

  typedef enum logic [4:0] {
    OP_READ       = 5'h00,
    OP_RESET      = 5'h01,
    OP_SR_READ    = 5'h02,
    OP_SR_CLEAR   = 5'h03,
    OP_PROG       = 5'h04,
    OP_BUF_PROG   = 5'h05,
    OP_ABORT_RST  = 5'h06,
    OP_BYP_ENTER  = 5'h07,
    OP_BYP_PROG   = 5'h08,
    OP_BYP_BUF    = 5'h09,
    OP_BYP_EXIT   = 5'h0a,
    OP_CHIP_ERASE = 5'h0b,
    OP_SECT_ERASE = 5'h0c,
    OP_SUSPEND    = 5'h0d,
    OP_RESUME     = 5'h0e,
    OP_PSUSPEND   = 5'h0f,
    OP_PRESUME    = 5'h10,
    OP_EVAL       = 5'h11,
    OP_BLANK      = 5'h12,
    OP_CFI_ENTER  = 5'h13,
    OP_CFI_EXIT   = 5'h14,
    OP_ID_ENTRY   = 5'h15,
    OP_SSR_ENTRY  = 5'h16,
    OP_LOCK_ENTRY = 5'h17,
    OP_PWD_ENTRY  = 5'h18,
    OP_SET_EXIT   = 5'h19,
    OP_OVL_PROG   = 5'h1a,
    OP_PWD_PROG   = 5'h1b
  } op_e;

  typedef enum logic [2:0] {
    K_END    = 3'h0,
    K_WR     = 3'h1,
    K_WR_SA  = 3'h2,
    K_WR_USR = 3'h3,
    K_WR_CNT = 3'h4,
    K_WR_BUF = 3'h5,
    K_RD_USR = 3'h6
  } kind_e;

  typedef struct packed {
    kind_e       kind;
    logic [11:0] addr;
    logic [7:0]  data;
  } step_s;

  typedef enum logic [1:0] {
    SQ_IDLE  = 2'h0,
    SQ_PREP  = 2'h1,
    SQ_ISSUE = 2'h2,
    SQ_WAIT  = 2'h3
  } seq_state_e;

  typedef enum logic [1:0] {
    BS_IDLE   = 2'h0,
    BS_SETUP  = 2'h1,
    BS_STROBE = 2'h2,
    BS_HOLD   = 2'h3
  } bus_state_e;

endpackage : flash_ctl_pkg

/* hw/flash_buf_mem.sv */
// byte store for write-buffer program data
`timescale 1ns/1ps
`default_nettype none
module flash_buf_mem #(
  parameter int DW    = 8,
  parameter int DEPTH = 256,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock
  input  wire logic          ref_clk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read side
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule : flash_buf_mem
`default_nettype wire

/* hw/flash_bus_cycle.sv */
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_params.svh"
module flash_bus_cycle
  import flash_ctl_pkg::*;
#(
  parameter int AW = 27,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // request
  input  wire logic          start,
  input  wire logic          rd,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic               done_q,
  output logic      [DW-1:0] rdata_q,
  // flash pins
  output logic               ce_n_q,
  output logic               we_n_q,
  output logic               oe_n_q,
  output logic      [AW-1:0] a_q,
  output logic      [DW-1:0] dq_o_q,
  output logic               dq_oe_q,
  input  wire logic [DW-1:0] dq_i
);
  bus_state_e    st_q, st_d;
  logic [3:0]    cnt_q, cnt_d;
  logic          rd_q, rd_d;
  logic [DW-1:0] s1_q, s2_q, s3_q;
  logic          done_d, ce_n_d, we_n_d, oe_n_d, dq_oe_d;
  logic [AW-1:0] a_d;
  logic [DW-1:0] dq_o_d, rdata_d;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    rd_d    = rd_q;
    done_d  = 1'b0;
    ce_n_d  = ce_n_q;
    we_n_d  = we_n_q;
    oe_n_d  = oe_n_q;
    a_d     = a_q;
    dq_o_d  = dq_o_q;
    dq_oe_d = dq_oe_q;
    rdata_d = rdata_q;
    case (st_q)
      BS_IDLE: begin
        if (start) begin
          st_d    = BS_SETUP;
          cnt_d   = 4'(`T_SETUP_CYC);
          rd_d    = rd;
          a_d     = addr;
          dq_o_d  = wdata;
          dq_oe_d = ~rd;
          ce_n_d  = 1'b0;
        end
      end
      BS_SETUP: begin
        cnt_d = cnt_q - 4'd1;
        if (cnt_q == 4'd1) begin
          st_d   = BS_STROBE;
          we_n_d = rd_q;
          oe_n_d = ~rd_q;
          // read strobe covers the input synchroniser latency
          cnt_d  = rd_q ? 4'(`T_STROBE_CYC + `SYNC_EXTRA_CYC)
                        : 4'(`T_STROBE_CYC);
        end
      end
      BS_STROBE: begin
        cnt_d = cnt_q - 4'd1;
        if (rd_q && s2_q == s3_q) begin
          rdata_d = s3_q;
        end
        if (cnt_q == 4'd1) begin
          st_d   = BS_HOLD;
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          cnt_d  = 4'(`T_HOLD_CYC);
        end
      end
      BS_HOLD: begin
        cnt_d = cnt_q - 4'd1;
        if (cnt_q == 4'd1) begin
          st_d    = BS_IDLE;
          ce_n_d  = 1'b1;
          dq_oe_d = 1'b0;
          done_d  = 1'b1;
        end
      end
      default: st_d = BS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    s1_q <= dq_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (rst) begin
      st_q    <= BS_IDLE;
      cnt_q   <= 4'd0;
      rd_q    <= 1'b0;
      done_q  <= 1'b0;
      ce_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      a_q     <= '0;
      dq_o_q  <= '0;
      dq_oe_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      rd_q    <= rd_d;
      done_q  <= done_d;
      ce_n_q  <= ce_n_d;
      we_n_q  <= we_n_d;
      oe_n_q  <= oe_n_d;
      a_q     <= a_d;
      dq_o_q  <= dq_o_d;
      dq_oe_q <= dq_oe_d;
      rdata_q <= rdata_d;
    end
  end
endmodule : flash_bus_cycle
`default_nettype wire

/* test/flash_host_ctl_sva.sv */
// port assertions for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctl_sva #(
  parameter int AW = 27
) (
  // clock and reset
  input wire logic          ref_clk,
  input wire logic          rst,
  // apb
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready_q,
  // flash pins
  input wire logic          flash_ce_n,
  input wire logic          flash_we_n,
  input wire logic          flash_oe_n,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [7:0]    flash_dq_o,
  input wire logic          flash_dq_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence apb_setup_s;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence we_pulse_s;
    !flash_we_n [*6] ##1 flash_we_n;
  endsequence
  apb_answer_a: assert property (apb_setup_s |-> !pready_q ##1 pready_q)
    else $error("apb answer off");
  no_rw_overlap_a: assert property (flash_we_n || flash_oe_n)
    else $error("write and read strobes overlap");
  we_in_ce_a: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("write strobe outside select");
  no_contend_a: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("host drives during read");
  we_width_a: assert property ($fell(flash_we_n) |-> we_pulse_s)
    else $error("write strobe width");
  we_setup_a: assert property ($fell(flash_we_n) |->
    !$past(flash_ce_n, 2) && $past(flash_ce_n, 3))
    else $error("select setup before strobe");
  wr_hold_a: assert property (!flash_we_n && !$past(flash_we_n) |->
    $stable(flash_addr) && $stable(flash_dq_o))
    else $error("address or data moved in strobe");
  ce_hold_a: assert property ($rose(flash_we_n) |->
    !flash_ce_n [*2] ##1 flash_ce_n)
    else $error("select hold after strobe");
endmodule : flash_host_ctl_sva
bind flash_host_ctl flash_host_ctl_sva #(.AW(AW)) sva_i (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pready_q(pready_q), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
  .flash_oe_n(flash_oe_n), .flash_addr(flash_addr),
  .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe)
);
`default_nettype wire

/* test/flash_dev_model.sv */
// behavioural byte-mode flash device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
  // strobes
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  // address and data
  input  wire logic [26:0] flash_addr,
  input  wire logic [7:0]  flash_dq_o,
  input  wire logic        flash_dq_oe,
  output logic      [7:0]  flash_dq_i
);
  logic [26:0] la [0:63];
  logic [7:0]  ld [0:63];
  int          n = 0;
  logic        stat_mode = 1'b0;
  logic [7:0]  last_q = 8'h00;
  // mode-select bit positions are a free choice of this model
  localparam int PERS_BIT = 1;
  localparam int PWD_BIT  = 2;
  logic        lock_md = 1'b0;
  logic [7:0]  lock_q = 8'hff;
  logic        rden;
  logic [7:0]  rd;
  assign rden = !flash_ce_n && !flash_oe_n;
  assign rd = stat_mode ? 8'h80 : lock_md ? lock_q
            : flash_addr[7:0] ^ 8'h5a;
  // a released bus must not look like held data
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : rden ? rd : ~last_q;
  always @(negedge rden) last_q = rd;
  always @(posedge flash_we_n) begin
    if (!flash_ce_n && n < 64) begin
      // decode keys on the data byte only; the address is logged but never decoded
      la[n] = flash_addr;
      ld[n] = flash_dq_i;
      n = n + 1;
      // any other command ends status output, reset and exits included
      stat_mode = flash_dq_i == 8'h70;
      if (lock_md && n > 1 && ld[n-2] == 8'ha0) begin
        // both protection modes at once drops back to array reads
        if (!flash_dq_i[PERS_BIT] && !flash_dq_i[PWD_BIT])
          lock_md = 1'b0;
        else
          lock_q = lock_q & flash_dq_i;
      end
      if (n > 1 && ld[n-2] == 8'h55) lock_md = flash_dq_i == 8'h40;
      if (flash_dq_i == 8'hf0) lock_md = 1'b0;
    end
  end
endmodule : flash_dev_model
`default_nettype wire

/* test/tb_flash_host_ctl.sv */
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_params.svh"
module tb_flash_host_ctl
  import flash_ctl_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q, rdat;
  logic        pready_q, pslverr_q, serr;
  logic        flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe;
  logic [26:0] flash_addr;
  logic [7:0]  flash_dq_o, flash_dq_i;
  logic [19:0] eq[$];
  int          err_count = 0;
  int          compares = 0;
  int          base = 0;

  initial forever #5 ref_clk = ~ref_clk;

  flash_host_ctl dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i));
  flash_dev_model fm (
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i));

  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; read data and error land in rdat and serr
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready_q !== 1'b1 && i < 20);
    rdat = prdata_q;
    serr = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready_q !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask : apb

  // start an op and poll busy; the model log from base on is its traffic
  task automatic do_op(input op_e op, input logic [1:0] part = 2'd0);
    int i;
    base = fm.n;
    apb(1'b1, `REG_CTRL, {14'h0, part, 7'h0, 1'b1, 3'h0, op});
    i = 0;
    do begin
      apb(1'b0, `REG_STATUS, 32'h0);
      i++;
    end while (rdat[0] !== 1'b0 && i < 100);
    if (rdat[0] !== 1'b0) begin
      err_count++;
      report_and_stop();
    end
  endtask : do_op

  task automatic chk_seq(input int cnt);
    chk(32'(fm.n - base), 32'(cnt));
    foreach (eq[k])
      chk({12'h0, fm.la[base+k][11:0], fm.ld[base+k]}, {12'h0, eq[k]});
  endtask : chk_seq

  task automatic single(input op_e op, input logic [7:0] code);
    do_op(op);
    chk(32'(fm.n - base), 32'h1);
    chk({24'h0, fm.ld[base]}, {24'h0, code});
  endtask : single

  task automatic chk_stat(input logic [31:0] exp);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk({24'h0, rdat[15:8]}, exp);
  endtask : chk_stat

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    chk({28'h0, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe}, 32'he);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, serr}, 32'h1);
    chk(rdat, 32'h0);
    apb(1'b1, `REG_ADDR, 32'h1234567);
    // upper bits of the data word must not reach the pins
    apb(1'b1, `REG_DATA, 32'h0000a53c);
    do_op(OP_PROG);
    eq = '{20'haaaaa, 20'h55555, 20'haaaa0, 20'h5673c};
    chk_seq(4);
    chk({5'h0, fm.la[base+3]}, 32'h1234567);
    single(OP_PSUSPEND, 8'h51);
    single(OP_PRESUME, 8'h50);
    single(OP_EVAL, 8'h35);
    single(OP_BLANK, 8'h33);
    single(OP_CFI_ENTER, 8'h98);
    single(OP_CFI_EXIT, 8'hff);
    single(OP_SR_CLEAR, 8'h71);
    do_op(OP_READ);
    chk(32'(fm.n - base), 32'h0);
    chk_stat(32'h3d);
    single(OP_SR_READ, 8'h70);
    chk_stat(32'h80);
    single(OP_RESET, 8'hf0);
    do_op(OP_SECT_ERASE);
    eq = '{20'haaaaa, 20'h55555, 20'haaa80, 20'haaaaa, 20'h55555};
    chk_seq(6);
    chk({24'h0, fm.ld[base+5]}, 32'h30);
    chk({17'h0, fm.la[base+5][26:12]}, 32'h1234);
    single(OP_SUSPEND, 8'hb0);
    do_op(OP_ID_ENTRY);
    eq = '{20'haaaaa, 20'h55555, 20'haaa90};
    chk_seq(3);
    single(OP_RESET, 8'hf0);
    single(OP_RESUME, 8'h30);
    do_op(OP_BYP_EXIT);
    chk(32'(fm.n - base), 32'h0);
    chk({28'h0, rdat[3:0]}, 32'h8);
    do_op(OP_BYP_ENTER);
    eq = '{20'haaaaa, 20'h55555, 20'haaa20};
    chk_seq(3);
    chk({28'h0, rdat[3:0]}, 32'h2);
    do_op(OP_BYP_PROG);
    chk(32'(fm.n - base), 32'h2);
    chk({16'h0, fm.ld[base], fm.ld[base+1]}, 32'ha03c);
    apb(1'b1, `REG_COUNT, 32'h1);
    apb(1'b1, `REG_BUF, 32'h11);
    apb(1'b1, `REG_BUF, 32'h22);
    apb(1'b0, `REG_BUF, 32'h0);
    chk(rdat, 32'h2);
    do_op(OP_BYP_BUF);
    eq = '{20'h00025, 20'h56701, 20'h56711, 20'h56822, 20'h00029};
    chk_seq(5);
    apb(1'b0, `REG_BUF, 32'h0);
    chk(rdat, 32'h0);
    do_op(OP_BYP_EXIT);
    chk(32'(fm.n - base), 32'h2);
    chk({16'h0, fm.ld[base], fm.ld[base+1]}, 32'h9000);
    chk({28'h0, rdat[3:0]}, 32'h0);
    do_op(OP_PWD_ENTRY);
    chk({29'h0, rdat[2:0]}, 32'h4);
    do_op(OP_PWD_PROG, 2'd1);
    chk({28'h0, rdat[3:0]}, 32'hc);
    apb(1'b1, `REG_ADDR, 32'h10);
    do_op(OP_PWD_PROG);
    eq = '{20'haaaa0, 20'h0103c};
    chk_seq(2);
    chk({30'h0, rdat[17:16]}, 32'h1);
    do_op(OP_SET_EXIT);
    eq = '{20'h00090, 20'h00000};
    chk_seq(2);
    chk({29'h0, rdat[2:0]}, 32'h0);
    do_op(OP_LOCK_ENTRY);
    apb(1'b1, `REG_DATA, 32'hfb);
    do_op(OP_OVL_PROG);
    apb(1'b1, `REG_DATA, 32'hff);
    do_op(OP_OVL_PROG);
    do_op(OP_READ);
    chk_stat(32'hfb);
    apb(1'b1, `REG_DATA, 32'hf9);
    do_op(OP_OVL_PROG);
    do_op(OP_READ);
    chk_stat(32'h4a);
    report_and_stop();
  end
endmodule : tb_flash_host_ctl
`default_nettype wire
